// ### sync_clock_regs.svh
// constants of the sync clock and pll input control block
// assumes a 32-bit classic wishbone slave, byte address = 4 * index
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef SYNC_CLOCK_REGS_SVH
`define SYNC_CLOCK_REGS_SVH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define OPC_IDX 6'h01
`define CPC_IDX 6'h02

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OPC_DROV_EN 13
`define OPC_SYNC_EN 11
`define OPC_SYNC_INV 10
`define CPC_DIV_RST 22
`define CPC_DIV_HI 21
`define CPC_DIV_LO 20
`define CPC_DBL_EN 19
`define CPC_PLL_EN 18
`define CPC_DIV_EN 17
`define CPC_DBL_EDGE 16

// ---------------------------------------------------------------
// reset values and writable masks
// ---------------------------------------------------------------
`define OPC_RST 32'h0000_0800
`define OPC_MASK 32'h0000_2C00
`define CPC_RST 32'h0000_0000
`define CPC_MASK 32'h007F_0000

`endif

// ### sync_clock_pkg.sv
// types of the sync clock and pll input control block
// assumes nothing beyond a systemverilog compiler
package sync_clock_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
  typedef logic [1:0] div_sel_t;
endpackage

// ### ref_input_divider.sv
// reference clock input divider working on reference ticks
// assumes ref_tick_i is a one-cycle pulse synchronous to clk_i
`include "sync_clock_regs.svh"
module ref_input_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic div_en_i,
  input wire logic div_rst_i,
  input wire sync_clock_pkg::div_sel_t div_sel_i,
  // ticks
  input wire logic ref_tick_i,
  output logic div_tick_o
);
  logic [2:0] cnt_q;
  logic [2:0] limit;

  assign limit = 3'(({2'b00, 1'b1} << div_sel_i) - 3'h1);

  // a held reset keeps the divider parked, so phase restarts on release
  always_ff @(posedge clk_i) begin
    if (rst_i || div_rst_i) begin
      cnt_q <= 3'h0;
      div_tick_o <= 1'b0;
    end else if (!div_en_i) begin
      cnt_q <= 3'h0;
      div_tick_o <= ref_tick_i;
    end else if (ref_tick_i) begin
      if (cnt_q >= limit) begin
        cnt_q <= 3'h0;
        div_tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 3'h1;
        div_tick_o <= 1'b0;
      end
    end else begin
      div_tick_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_div_rst;
    div_rst_i |=> (cnt_q == 3'h0) && !div_tick_o;
  endproperty
  a_div_rst: assert property (p_div_rst)
    else $error("divider not reset");

  property p_div_tick;
    div_en_i && !div_rst_i && ref_tick_i && (cnt_q >= limit)
      |=> div_tick_o;
  endproperty
  a_div_tick: assert property (p_div_tick)
    else $error("divided tick missing");

  property p_div_quiet;
    div_en_i && !(ref_tick_i && (cnt_q >= limit)) |=> !div_tick_o;
  endproperty
  a_div_quiet: assert property (p_div_quiet)
    else $error("divided tick too early");

  property p_div_bypass;
    !div_en_i && !div_rst_i |=> div_tick_o == $past(ref_tick_i);
  endproperty
  a_div_bypass: assert property (p_div_bypass)
    else $error("bypass does not follow reference");
endmodule // ref_input_divider

// ### sync_clock_out.sv
// internal sync clock, its output pin and the I/Q phase marker
// assumes sys_tick_i is one system clock tick per pulse
module sync_clock_out (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic pin_en_i,
  input wire logic invert_i,
  input wire logic sys_tick_i,
  // outputs
  output logic sync_pin_o,
  output logic q_phase_o,
  output logic asm_tick_o
);
  logic sync_q;
  logic sync_d;

  assign sync_d = sys_tick_i ? !sync_q : sync_q;

  // internal clock never stops, so the data assembler keeps its timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
      asm_tick_o <= 1'b0;
      q_phase_o <= 1'b0;
    end else begin
      sync_q <= sync_d;
      asm_tick_o <= sys_tick_i && !sync_q;
      q_phase_o <= sync_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pin_o <= 1'b0;
    end else if (!pin_en_i) begin
      sync_pin_o <= 1'b0;
    end else begin
      sync_pin_o <= sync_d ^ invert_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pin_low;
    !pin_en_i |=> !sync_pin_o;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("sync pin not held low");

  property p_keeps_running;
    !pin_en_i && sys_tick_i |=> sync_q != $past(sync_q);
  endproperty
  a_keeps_running: assert property (p_keeps_running)
    else $error("internal sync clock stopped");

  property p_pin_shows;
    pin_en_i |=> sync_pin_o == (q_phase_o ^ $past(invert_i));
  endproperty
  a_pin_shows: assert property (p_pin_shows)
    else $error("sync pin does not follow internal clock");
endmodule // sync_clock_out

// ### sync_clock_and_pll_input_control.sv
// top of the sync clock and pll input control block
// assumes a classic wishbone master and reference/pll tick pulses
`include "sync_clock_regs.svh"
module sync_clock_and_pll_input_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock path inputs
  input wire logic ref_tick_i,
  input wire logic pll_tick_i,
  input wire logic ramp_over_i,
  // outputs
  output logic ramp_over_indicator_o,
  output logic sync_clk_o,
  output logic q_phase_o,
  output logic assembler_tick_o,
  output logic sys_tick_o,
  output logic pll_enable_o,
  output logic doubler_active_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sync_clock_pkg::bus_state_t state_q;
  sync_clock_pkg::bus_state_t state_d;
  logic [31:0] output_pin_control_q;
  logic [31:0] clock_path_config_q;
  logic [31:0] opc_merge;
  logic [31:0] cpc_merge;
  logic [31:0] rdata;
  logic req;
  logic hit_opc;
  logic hit_cpc;
  logic wr_take;
  logic div_tick;
  logic sys_tick_q;
  logic pll_en;
  logic div_en;
  logic div_rst;
  logic dbl_en;
  logic dbl_edge;
  sync_clock_pkg::div_sel_t div_sel;

  assign req = wb_cyc_i && wb_stb_i;
  assign pll_en = clock_path_config_q[`CPC_PLL_EN];
  assign div_en = clock_path_config_q[`CPC_DIV_EN];
  assign div_rst = clock_path_config_q[`CPC_DIV_RST];
  assign dbl_en = clock_path_config_q[`CPC_DBL_EN];
  assign dbl_edge = clock_path_config_q[`CPC_DBL_EDGE];
  assign div_sel = clock_path_config_q[`CPC_DIV_HI:`CPC_DIV_LO];

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle gives a registered ack and registered read data
  always_comb begin
    state_d = state_q;
    case (state_q)
      sync_clock_pkg::BUS_IDLE: begin
        if (req) begin
          state_d = sync_clock_pkg::BUS_ACK;
        end
      end
      sync_clock_pkg::BUS_ACK: begin
        state_d = sync_clock_pkg::BUS_IDLE;
      end
      default: begin
        state_d = sync_clock_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sync_clock_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      state_q <= state_d;
      wb_ack_o <= (state_d == sync_clock_pkg::BUS_ACK);
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    hit_opc = 1'b0;
    hit_cpc = 1'b0;
    if (wb_adr_i[7:2] == `OPC_IDX) begin
      hit_opc = 1'b1;
    end else if (wb_adr_i[7:2] == `CPC_IDX) begin
      hit_cpc = 1'b1;
    end
  end

  // unmapped words read as zero and ignore writes
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_opc) begin
      rdata = output_pin_control_q;
    end else if (hit_cpc) begin
      rdata = clock_path_config_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && state_q == sync_clock_pkg::BUS_IDLE) begin
      wb_dat_o <= rdata;
    end else if (!req) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // a write lands on the same edge the master samples ack
  assign wr_take = req && wb_we_i && wb_ack_o;

  for (genvar gb = 0; gb < 4; gb++) begin : g_lane
    assign opc_merge[8*gb +: 8] = wb_sel_i[gb] ?
      wb_dat_i[8*gb +: 8] : output_pin_control_q[8*gb +: 8];
    assign cpc_merge[8*gb +: 8] = wb_sel_i[gb] ?
      wb_dat_i[8*gb +: 8] : clock_path_config_q[8*gb +: 8];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_pin_control_q <= `OPC_RST;
    end else if (wr_take && hit_opc) begin
      output_pin_control_q <= opc_merge & `OPC_MASK;
    end
  end

  // divider reset bit is a level: the divider stays parked while set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_path_config_q <= `CPC_RST;
    end else if (wr_take && hit_cpc) begin
      clock_path_config_q <= cpc_merge & `CPC_MASK;
    end
  end

  // ---------------------------------------------------------------
  // reference path and system clock select
  // ---------------------------------------------------------------
  ref_input_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_en_i(div_en),
    .div_rst_i(div_rst),
    .div_sel_i(div_sel),
    .ref_tick_i(ref_tick_i),
    .div_tick_o(div_tick)
  );

  // pll multiplication is analog; here it only picks the tick source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_tick_q <= 1'b0;
    end else if (pll_en) begin
      sys_tick_q <= pll_tick_i;
    end else begin
      sys_tick_q <= div_tick;
    end
  end

  assign sys_tick_o = sys_tick_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_enable_o <= 1'b0;
    end else begin
      pll_enable_o <= pll_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doubler_active_o <= 1'b0;
    end else begin
      doubler_active_o <= dbl_en && dbl_edge;
    end
  end

  // ---------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_over_indicator_o <= 1'b0;
    end else if (output_pin_control_q[`OPC_DROV_EN]) begin
      ramp_over_indicator_o <= ramp_over_i;
    end else begin
      ramp_over_indicator_o <= 1'b0;
    end
  end

  sync_clock_out u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_en_i(output_pin_control_q[`OPC_SYNC_EN]),
    .invert_i(output_pin_control_q[`OPC_SYNC_INV]),
    .sys_tick_i(sys_tick_q),
    .sync_pin_o(sync_clk_o),
    .q_phase_o(q_phase_o),
    .asm_tick_o(assembler_tick_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_new_req;
    req && !wb_ack_o && state_q == sync_clock_pkg::BUS_IDLE;
  endsequence

  sequence s_wr_cpc(int b);
    wr_take && hit_cpc && wb_sel_i[b / 8] && wb_dat_i[b];
  endsequence

  property p_bus_ack;
    s_new_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("ack not given for one cycle");

  property p_ramp_off;
    !output_pin_control_q[`OPC_DROV_EN] |=> !ramp_over_indicator_o;
  endproperty
  a_ramp_off: assert property (p_ramp_off)
    else $error("ramp-over output driven while disabled");

  property p_ramp_on;
    output_pin_control_q[`OPC_DROV_EN]
      |=> ramp_over_indicator_o == $past(ramp_over_i);
  endproperty
  a_ramp_on: assert property (p_ramp_on)
    else $error("ramp-over output does not follow");

  property p_sync_off;
    !output_pin_control_q[`OPC_SYNC_EN] [*2] |-> !sync_clk_o;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync pin active while disabled");

  // the pin was registered with last cycle's invert bit, so compare to that
  property p_sync_on;
    output_pin_control_q[`OPC_SYNC_EN] [*2] |->
      sync_clk_o == (q_phase_o ^ $past(output_pin_control_q[`OPC_SYNC_INV]));
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("sync pin not showing internal clock");

  property p_div_rst_wr;
    s_wr_cpc(`CPC_DIV_RST) |=> div_rst ##1 !div_tick;
  endproperty
  a_div_rst_wr: assert property (p_div_rst_wr)
    else $error("divider reset write had no effect");

  property p_div_sel;
    s_wr_cpc(`CPC_DIV_HI) |=> div_sel[1];
  endproperty
  a_div_sel: assert property (p_div_sel)
    else $error("divider select not stored");

  property p_div_bypass;
    !div_en && !div_rst && !pll_en [*2]
      |=> sys_tick_o == $past(ref_tick_i, 2);
  endproperty
  a_div_bypass: assert property (p_div_bypass)
    else $error("undivided reference not passed through");

  property p_doubler;
    ##1 doubler_active_o == $past(dbl_en && dbl_edge);
  endproperty
  a_doubler: assert property (p_doubler)
    else $error("doubler state wrong");

  property p_doubler_edge;
    !dbl_edge |=> !doubler_active_o;
  endproperty
  a_doubler_edge: assert property (p_doubler_edge)
    else $error("doubler active without edge bit");

  property p_pll_sel;
    pll_en |=> pll_enable_o && sys_tick_o == $past(pll_tick_i);
  endproperty
  a_pll_sel: assert property (p_pll_sel)
    else $error("pll not selected as system clock");

  property p_ref_sel;
    !pll_en |=> !pll_enable_o && sys_tick_o == $past(div_tick);
  endproperty
  a_ref_sel: assert property (p_ref_sel)
    else $error("reference path not selected");

endmodule // sync_clock_and_pll_input_control

// ### sync_clock_and_pll_input_control_tb.sv
// self-checking bench of the sync clock and pll input control block
// assumes the design header and package are compiled first
`include "sync_clock_regs.svh"
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); \
  end \
end
module sync_clock_and_pll_input_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, opc_m, cpc_m, rd;
  logic ref_tick_i, pll_tick_i, ramp_over_i, ro_s, pll_s, q_prev;
  logic ramp_over_indicator_o, sync_clk_o, q_phase_o, assembler_tick_o;
  logic sys_tick_o, pll_enable_o, doubler_active_o;
  int errors, comparisons, quiet, sys_cnt, q_cnt, asm_cnt, rise_cnt;
  integer seed;
  sync_clock_and_pll_input_control i_sync_clock_and_pll_input_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ref_tick_i(ref_tick_i),
    .pll_tick_i(pll_tick_i), .ramp_over_i(ramp_over_i),
    .ramp_over_indicator_o(ramp_over_indicator_o),
    .sync_clk_o(sync_clk_o), .q_phase_o(q_phase_o),
    .assembler_tick_o(assembler_tick_o), .sys_tick_o(sys_tick_o),
    .pll_enable_o(pll_enable_o), .doubler_active_o(doubler_active_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // closing report
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // wishbone classic master, model updated at the ack edge
  // ---------------------------------------------------------------
  function automatic logic [31:0] mread(logic [7:0] a);
    case (a[7:2])
      6'h01: return opc_m;
      6'h02: return cpc_m;
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    logic [31:0] bm;
    int n;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      quiet = 4;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out();
    end
    rd = wb_dat_o;
    if (!we) `CHK("rdata", mread(a), rd)
    if (we && a[7:2] == 6'h01) opc_m = (opc_m & ~(bm & `OPC_MASK))
      | (d & bm & `OPC_MASK);
    if (we && a[7:2] == 6'h02) cpc_m = (cpc_m & ~(bm & `CPC_MASK))
      | (d & bm & `CPC_MASK);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ---------------------------------------------------------------
  // tick bursts, counted against the divide ratio
  // ---------------------------------------------------------------
  task automatic burst(input int n, input logic use_pll, input int exp);
    repeat (6) @(posedge clk_i);
    sys_cnt = 0;
    q_cnt = 0;
    asm_cnt = 0;
    rise_cnt = 0;
    repeat (n) begin
      if (use_pll) pll_tick_i <= 1'b1;
      else ref_tick_i <= 1'b1;
      @(posedge clk_i);
      pll_tick_i <= 1'b0;
      ref_tick_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    `CHK("sys_ticks", exp, sys_cnt)
    `CHK("q_toggles", sys_cnt, q_cnt)
    `CHK("asm_ticks", rise_cnt, asm_cnt)
  endtask
  // ---------------------------------------------------------------
  // per-cycle model comparison
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    ro_s <= ramp_over_i;
    pll_s <= pll_tick_i;
    ramp_over_i <= 1'($random(seed));
    if (quiet > 0) quiet--;
  end
  always @(negedge clk_i) begin
    if (!rst_i) begin
      sys_cnt += int'(sys_tick_o);
      asm_cnt += int'(assembler_tick_o);
      if (q_phase_o !== q_prev) q_cnt++;
      if (q_phase_o === 1'b1 && q_prev === 1'b0) rise_cnt++;
      q_prev = q_phase_o;
    end
    if (!rst_i && quiet == 0) begin
      `CHK("ramp", opc_m[13] & ro_s, ramp_over_indicator_o)
      `CHK("sync", opc_m[11] & (q_phase_o ^ opc_m[10]), sync_clk_o)
      `CHK("pll_en", cpc_m[18], pll_enable_o)
      `CHK("dbl", cpc_m[19] & cpc_m[16], doubler_active_o)
      if (cpc_m[18]) `CHK("pll_tick", pll_s, sys_tick_o)
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] opc_set [4];
    opc_set = '{32'h0000_0800, 32'h0000_0C00, 32'h0000_0000, 32'h0000_2400};
    seed = 32'h3ab0;
    errors = 0;
    comparisons = 0;
    quiet = 4;
    q_prev = 1'b0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, ref_tick_i, pll_tick_i} = 5'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    opc_m = `OPC_RST;
    cpc_m = `CPC_RST;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, masks, byte enables, unmapped word
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    wb(1'b0, 8'h08, 4'hF, 32'h0);
    wb(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    wb(1'b1, 8'h04, 4'hD, 32'h0000_0000);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 4'hF, 32'h0);
    repeat (20) @(posedge clk_i);
    // every divide code, with reset held first, under varied pin modes
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h04, 4'hF, opc_set[c]);
      wb(1'b1, 8'h08, 4'hF, 32'h0042_0000 | (c << 20));
      burst(4, 1'b0, 0);
      wb(1'b1, 8'h08, 4'hF, 32'h0002_0000 | (c << 20));
      burst(16, 1'b0, 16 >> c);
      wb(1'b0, 8'h08, 4'hF, 32'h0);
    end
    // divider off: every reference tick passes despite code 11
    wb(1'b1, 8'h08, 4'hF, 32'h0030_0000);
    burst(16, 1'b0, 16);
    // doubler flag over all four combinations
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, 8'h08, 4'hF, {12'h000, d[1], 2'b00, d[0], 16'h0000});
      repeat (10) @(posedge clk_i);
    end
    // pll on and a write to unmapped word 0, then pll ticks drive the system clock
    wb(1'b1, 8'h08, 4'hF, 32'h0004_0000);
    wb(1'b1, 8'h00, 4'hF, 32'h0100_0000);
    burst(12, 1'b1, 12);
    burst(6, 1'b0, 0);
    // second reset in mid-run restores the defaults
    rst_i <= 1'b1;
    @(posedge clk_i);
    opc_m = `OPC_RST;
    cpc_m = `CPC_RST;
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    wb(1'b0, 8'h08, 4'hF, 32'h0);
    repeat (20) @(posedge clk_i);
    close_out();
  end
endmodule // sync_clock_and_pll_input_control_tb
